//--- testbench/mctm_host_model.sv
// Host side APB master model for the temp monitor register bank
`timescale 1ns/100ps
module mctm_host_model
  import mctm_pkg::*;
(
  input  wire logic          sys_clk,
  output mctm_apb_req_t      apb_req,
  input  wire mctm_apb_rsp_t apb_rsp
);
  // Bus idles with nothing selected
  initial apb_req = '0;

  // One transfer: setup, access until pready, then one idle cycle
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    apb_req <= '{1'b1, 1'b0, wr, {2'b00, idx, 2'b00}, {24'h0, wd}};
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    // Wait for the answer; only the bench watchdog bounds a hang
    do begin
      @(posedge sys_clk);
    end while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge sys_clk);
  endtask : xfer
endmodule : mctm_host_model

//--- testbench/tb_top.sv
// Self-checking bench for the temp monitor register bank
`timescale 1ns/100ps
module tb_top
  import mctm_pkg::*;
();
  logic                    sys_clk = 1'b0;
  logic                    rstn = 1'b0;
  mctm_apb_req_t           apb_req;
  mctm_apb_rsp_t           apb_rsp;
  mctm_reading_t [NCH-1:0] reading = '0;
  mctm_cond_t              cond = '0;
  logic [2:0]              remote_count = 3'h7;
  logic                    standby_pin = 1'b0;
  logic                    alert;
  logic                    standby_state;
  logic                    averaging_disable;
  logic                    peak_en;
  logic                    tick;
  logic [31:0]             rdv;
  logic                    err;
  int                      mismatches = 0;
  int                      total_checks = 0;
  // Shortened tick periods per rate code, code 7 with seven remotes
  localparam int RATE_PER [8] = '{80, 80, 80, 80, 200, 120, 80, 60};
  localparam int CONT_PER [4] = '{40, 46, 54, 60};
  localparam logic [7:0] INT_IDX [NCH] = '{IDX_INT_INTEGER, IDX_R1_INTEGER,
    IDX_R2_INTEGER, IDX_R3_INTEGER, IDX_R4_INTEGER, IDX_R5_INTEGER, IDX_R6_INTEGER,
    IDX_R7_INTEGER};
  localparam logic [7:0] FRAC_IDX [NCH] = '{IDX_INT_FRACTION, IDX_R1_FRACTION,
    IDX_R2_FRACTION, IDX_R3_FRACTION, IDX_R4_FRACTION, IDX_R5_FRACTION, IDX_R6_FRACTION,
    IDX_R7_FRACTION};
  localparam logic [7:0] CLR_IDX [3] = '{IDX_HIGH_STATUS, IDX_LOW_STATUS, IDX_FAULT_STATUS};

  mctm_regs #(.P_1HZ(RATE_PER[4]), .P_2HZ(RATE_PER[5]), .P_4HZ(RATE_PER[6]),
    .P_15HZ(CONT_PER[0]), .P_13HZ(CONT_PER[1]), .P_11HZ(CONT_PER[2]),
    .P_10HZ(CONT_PER[3])) dut (.sys_clk(sys_clk), .rstn(rstn), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .reading(reading), .cond(cond), .remote_count(remote_count),
    .standby_pin(standby_pin), .alert(alert), .standby_state(standby_state),
    .averaging_disable(averaging_disable), .remote_peak_compare_enable(peak_en),
    .convert_tick(tick));
  mctm_host_model host (.sys_clk(sys_clk), .apb_req(apb_req), .apb_rsp(apb_rsp));

  // Compare, read-and-compare and write helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    host.xfer(1'b0, idx, 8'h00, rdv, err);
    chk($sformatf("reg %h", idx), exp, rdv);
  endtask : rd
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    host.xfer(1'b1, idx, d, rdv, err);
  endtask : wr
  task automatic wait_alert(input logic exp);
    int n;
    for (n = 0; n < 8 && alert !== exp; n++) @(posedge sys_clk);
    chk("alert", exp, alert);
  endtask : wait_alert
  // Cycles between the second and third tick seen
  task automatic tick_gap(output int gap);
    int n;
    n = 0;
    gap = 0;
    while (n < 3 && gap < 1000) begin
      @(posedge sys_clk);
      gap++;
      if (tick === 1'b1) begin
        n++;
        if (n < 3) gap = 0;
      end
    end
  endtask : tick_gap

  task automatic t_reset;
    rd(IDX_SETUP_A, 32'h80);
    rd(IDX_SETUP_B, 32'h80);
    rd(IDX_RATE_A, 32'h06);
    rd(IDX_RATE_B, 32'h06);
    rd(IDX_EVENT_FLAGS, 32'h00);
    chk("alert", 1'b0, alert);
    chk("peak enable", 1'b1, peak_en);
    host.xfer(1'b0, 8'h3f, 8'h00, rdv, err);
    chk("slave error", 1'b1, err);
    chk("unmapped data", 32'h0, rdv);
    $display("test reset done");
  endtask : t_reset

  task automatic t_setup;
    wr(IDX_SETUP_A, 8'hff);
    rd(IDX_SETUP_B, 32'he2);
    chk("standby", 1'b1, standby_state);
    chk("averaging off", 1'b1, averaging_disable);
    wr(IDX_SETUP_B, 8'h00);
    rd(IDX_SETUP_A, 32'h00);
    chk("standby", 1'b0, standby_state);
    chk("averaging off", 1'b0, averaging_disable);
    standby_pin <= 1'b1;
    @(posedge sys_clk);
    chk("standby", 1'b1, standby_state);
    rd(IDX_SETUP_A, 32'h00);
    standby_pin <= 1'b0;
    $display("test setup done");
  endtask : t_setup

  task automatic t_rate;
    int g;
    for (int c = 0; c < 8; c++) begin
      wr(c[0] ? IDX_RATE_B : IDX_RATE_A, 8'hf8 | 8'(c));
      rd(c[0] ? IDX_RATE_A : IDX_RATE_B, 32'(c));
      tick_gap(g);
      chk("tick gap", RATE_PER[c], g);
    end
    for (int r = 4; r < 8; r++) begin
      remote_count <= 3'(r);
      tick_gap(g);
      chk("continuous gap", CONT_PER[r-4], g);
    end
    wr(IDX_RATE_A, 8'h06);
    $display("test rate done");
  endtask : t_rate

  task automatic t_interlock;
    for (int ch = 0; ch < NCH; ch++) begin
      reading[ch] <= '{8'hc0 + 8'(ch), 3'(ch), 1'b0};
      @(posedge sys_clk);
      rd(INT_IDX[ch], 32'hc0 + 32'(ch));
      reading[ch].fraction <= 3'h7 - 3'(ch);
      wr(INT_IDX[ch], 8'h55);
      wr(FRAC_IDX[ch], 8'hff);
      rd(FRAC_IDX[ch], {24'h0, 3'(ch), 5'h0});
      rd(INT_IDX[ch], 32'hc0 + 32'(ch));
      rd(FRAC_IDX[ch], {24'h0, 3'h7 - 3'(ch), 5'h0});
    end
    $display("test interlock done");
  endtask : t_interlock

  task automatic t_fault;
    reading[3] <= '{8'h7f, 3'h7, 1'b1};
    @(posedge sys_clk);
    rd(IDX_R3_INTEGER, 32'h80);
    rd(IDX_R3_FRACTION, 32'h00);
    reading[3].fault <= 1'b0;
    @(posedge sys_clk);
    rd(IDX_R3_INTEGER, 32'h7f);
    rd(IDX_R3_FRACTION, 32'he0);
    $display("test fault code done");
  endtask : t_fault

  // In interrupt mode, high, low and fault flags stick until a clearing read with the cause gone
  task automatic t_flags;
    for (int i = 0; i < 3; i++) begin
      cond <= mctm_cond_t'(6'h08 >> i);
      @(posedge sys_clk);
      host.xfer(1'b0, CLR_IDX[i], 8'h00, rdv, err);
      rd(IDX_EVENT_FLAGS, 32'h10 >> i);
      cond <= '0;
      wr(IDX_EVENT_FLAGS, 8'h00);
      rd(IDX_EVENT_FLAGS, 32'h10 >> i);
      host.xfer(1'b0, CLR_IDX[i], 8'h00, rdv, err);
      rd(IDX_EVENT_FLAGS, 32'h00);
    end
    cond <= mctm_cond_t'(6'h10);
    @(posedge sys_clk);
    cond <= '0;
    @(posedge sys_clk);
    rd(IDX_EVENT_FLAGS, 32'h40);
    rd(IDX_EVENT_FLAGS, 32'h00);
    cond <= mctm_cond_t'(6'h20);
    rd(IDX_EVENT_FLAGS, 32'h80);
    chk("alert", 1'b0, alert);
    cond <= mctm_cond_t'(6'h01);
    rd(IDX_EVENT_FLAGS, 32'h02);
    cond <= '0;
    rd(IDX_EVENT_FLAGS, 32'h00);
    $display("test flags done");
  endtask : t_flags

  task automatic t_alert;
    wr(IDX_SETUP_A, 8'h80);
    cond <= mctm_cond_t'(6'h08);
    rd(IDX_EVENT_FLAGS, 32'h10);
    chk("alert", 1'b0, alert);
    wr(IDX_SETUP_A, 8'h00);
    wait_alert(1'b1);
    cond <= '0;
    host.xfer(1'b0, IDX_HIGH_STATUS, 8'h00, rdv, err);
    wait_alert(1'b0);
    wr(IDX_SETUP_B, 8'ha0);
    cond <= mctm_cond_t'(6'h08);
    wait_alert(1'b1);
    rd(IDX_EVENT_FLAGS, 32'h10);
    cond <= '0;
    wait_alert(1'b0);
    rd(IDX_EVENT_FLAGS, 32'h00);
    wr(IDX_SETUP_A, 8'h80);
    $display("test alert done");
  endtask : t_alert

  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  // Clock, reset and test sequence
  always #5 sys_clk = ~sys_clk;
  initial begin
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_setup;
    t_rate;
    t_interlock;
    t_fault;
    t_flags;
    t_alert;
    tally_and_finish;
  end
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish;
  end
endmodule : tb_top

//--- verilog/mctm_pkg.sv
// Package of register map, field positions, reset values and timing for the temp monitor regs
package mctm_pkg;

  // Register offsets (printed offsets are not all multiples of four: index, byte addr = 4*index)
  localparam logic [7:0] IDX_INT_INTEGER   = 8'h00;
  localparam logic [7:0] IDX_R1_INTEGER    = 8'h01;
  localparam logic [7:0] IDX_EVENT_FLAGS   = 8'h02;
  localparam logic [7:0] IDX_SETUP_A       = 8'h03;
  localparam logic [7:0] IDX_RATE_A        = 8'h04;
  localparam logic [7:0] IDX_SETUP_B       = 8'h09;
  localparam logic [7:0] IDX_RATE_B        = 8'h0a;
  localparam logic [7:0] IDX_R1_FRACTION   = 8'h10;
  localparam logic [7:0] IDX_R2_INTEGER    = 8'h23;
  localparam logic [7:0] IDX_R2_FRACTION   = 8'h24;
  localparam logic [7:0] IDX_INT_FRACTION  = 8'h29;
  localparam logic [7:0] IDX_R3_INTEGER    = 8'h2a;
  localparam logic [7:0] IDX_R3_FRACTION   = 8'h2b;
  localparam logic [7:0] IDX_R4_INTEGER    = 8'h41;
  localparam logic [7:0] IDX_R4_FRACTION   = 8'h42;
  localparam logic [7:0] IDX_R5_INTEGER    = 8'h43;
  localparam logic [7:0] IDX_R5_FRACTION   = 8'h44;
  localparam logic [7:0] IDX_R6_INTEGER    = 8'h45;
  localparam logic [7:0] IDX_R6_FRACTION   = 8'h46;
  localparam logic [7:0] IDX_R7_INTEGER    = 8'h47;
  localparam logic [7:0] IDX_R7_FRACTION   = 8'h48;
  // Status-clearing reads of the high (interrupt mode only), low and fault status registers
  localparam logic [7:0] IDX_HIGH_STATUS   = 8'h35;
  localparam logic [7:0] IDX_LOW_STATUS    = 8'h36;
  localparam logic [7:0] IDX_FAULT_STATUS  = 8'h37;

  // Reset values and fault code
  localparam logic [7:0] SETUP_RESET = 8'h80;
  localparam logic [7:0] RATE_RESET  = 8'h06;
  localparam logic [7:0] FAULT_CODE_INT  = 8'h80;
  localparam logic [2:0] FAULT_CODE_FRAC = 3'h0;

  // Field positions
  localparam int SETUP_MASK_BIT    = 7;
  localparam int SETUP_STANDBY_BIT = 6;
  localparam int SETUP_COMP_BIT    = 5;
  localparam int SETUP_AVG_DIS_BIT = 1;
  localparam logic [7:0] SETUP_WMASK = 8'he2;
  localparam logic [7:0] RATE_WMASK  = 8'h07;
  localparam int FLAG_BUSY  = 7;
  localparam int FLAG_PEAK  = 6;
  localparam int FLAG_HIGH  = 4;
  localparam int FLAG_LOW   = 3;
  localparam int FLAG_FAULT = 2;
  localparam int FLAG_CRIT  = 1;

  // Channel count: 0 internal, 1..7 remote
  localparam int NCH = 8;

  // Rate codes
  localparam logic [2:0] RATE_1HZ  = 3'h4;
  localparam logic [2:0] RATE_2HZ  = 3'h5;
  localparam logic [2:0] RATE_4HZ  = 3'h6;
  localparam logic [2:0] RATE_CONT = 3'h7;

  // Timing: clock 100 MHz
  localparam longint CLK_HZ = 100000000;
  localparam longint PERIOD_1HZ  = CLK_HZ / 1;
  localparam longint PERIOD_2HZ  = CLK_HZ / 2;
  localparam longint PERIOD_4HZ  = CLK_HZ / 4;
  localparam longint PERIOD_15HZ = CLK_HZ / 15;
  localparam longint PERIOD_13HZ = CLK_HZ / 13;
  localparam longint PERIOD_11HZ = CLK_HZ / 11;
  localparam longint PERIOD_10HZ = CLK_HZ / 10;

  // One channel reading from the converter
  typedef struct packed {
    logic [7:0] integer_part;
    logic [2:0] fraction;
    logic       fault;
  } mctm_reading_t;

  // APB request bundle
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } mctm_apb_req_t;

  // APB answer bundle
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } mctm_apb_rsp_t;

  // Live conditions from the converter and comparators
  typedef struct packed {
    logic busy;
    logic peak_change;
    logic high_hit;
    logic low_hit;
    logic diode_fault;
    logic crit_hit;
  } mctm_cond_t;

endpackage : mctm_pkg

//--- verilog/mctm_regs.sv
// Register bank of the multi-channel temperature monitor behind an APB slave
//
// The APB register port was decided locally.
`timescale 1ns/100ps
module mctm_regs
  import mctm_pkg::*;
#(
  parameter longint P_1HZ  = PERIOD_1HZ,
  parameter longint P_2HZ  = PERIOD_2HZ,
  parameter longint P_4HZ  = PERIOD_4HZ,
  parameter longint P_15HZ = PERIOD_15HZ,
  parameter longint P_13HZ = PERIOD_13HZ,
  parameter longint P_11HZ = PERIOD_11HZ,
  parameter longint P_10HZ = PERIOD_10HZ
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire mctm_apb_req_t         apb_req,
  output mctm_apb_rsp_t              apb_rsp,
  input  wire mctm_reading_t [NCH-1:0] reading,
  input  wire mctm_cond_t            cond,
  input  wire logic [2:0]            remote_count,
  input  wire logic                  standby_pin,
  output logic                       alert,
  output logic                       standby_state,
  output logic                       averaging_disable,
  output logic                       remote_peak_compare_enable,
  output logic                       convert_tick
);

  // Whole module state
  typedef struct packed {
    logic [7:0]            setup;
    logic [2:0]            rate_code;
    logic [7:0]            flags;
    logic [NCH-1:0][7:0]   held_fraction;
    logic [31:0]           prdata;
    logic                  alert;
    logic [31:0]           rate_cnt;
    logic                  tick;
  } mctm_state_t;

  mctm_state_t st;
  mctm_state_t next_st;

  // Format one channel reading into integer and fraction bytes
  function automatic logic [15:0] mctm_format(input mctm_reading_t r);
    if (r.fault) begin
      mctm_format = {FAULT_CODE_INT, FAULT_CODE_FRAC, 5'h00};
    end else begin
      mctm_format = {r.integer_part, r.fraction, 5'h00};
    end
  endfunction : mctm_format

  // Map an integer-byte index to a channel, or -1
  function automatic int mctm_int_chan(input logic [7:0] idx);
    case (idx)
      IDX_INT_INTEGER: mctm_int_chan = 0;
      IDX_R1_INTEGER:  mctm_int_chan = 1;
      IDX_R2_INTEGER:  mctm_int_chan = 2;
      IDX_R3_INTEGER:  mctm_int_chan = 3;
      IDX_R4_INTEGER:  mctm_int_chan = 4;
      IDX_R5_INTEGER:  mctm_int_chan = 5;
      IDX_R6_INTEGER:  mctm_int_chan = 6;
      IDX_R7_INTEGER:  mctm_int_chan = 7;
      default:         mctm_int_chan = -1;
    endcase
  endfunction : mctm_int_chan

  // Map a fraction-byte index to a channel, or -1
  function automatic int mctm_frac_chan(input logic [7:0] idx);
    case (idx)
      IDX_INT_FRACTION: mctm_frac_chan = 0;
      IDX_R1_FRACTION:  mctm_frac_chan = 1;
      IDX_R2_FRACTION:  mctm_frac_chan = 2;
      IDX_R3_FRACTION:  mctm_frac_chan = 3;
      IDX_R4_FRACTION:  mctm_frac_chan = 4;
      IDX_R5_FRACTION:  mctm_frac_chan = 5;
      IDX_R6_FRACTION:  mctm_frac_chan = 6;
      IDX_R7_FRACTION:  mctm_frac_chan = 7;
      default:          mctm_frac_chan = -1;
    endcase
  endfunction : mctm_frac_chan

  // Cycle period for the selected rate
  function automatic logic [31:0] mctm_period(input logic [2:0] code, input logic [2:0] nrem);
    case (code)
      RATE_1HZ:  mctm_period = 32'(P_1HZ);
      RATE_2HZ:  mctm_period = 32'(P_2HZ);
      RATE_CONT: begin
        case (nrem)
          3'h7:    mctm_period = 32'(P_10HZ);
          3'h6:    mctm_period = 32'(P_11HZ);
          3'h5:    mctm_period = 32'(P_13HZ);
          default: mctm_period = 32'(P_15HZ);
        endcase
      end
      default:   mctm_period = 32'(P_4HZ);
    endcase
  endfunction : mctm_period

  logic       acc;
  logic       wr;
  logic       rd;
  logic [7:0] idx;
  logic       mapped;
  logic [15:0] fmt [NCH];
  logic       comp_mode;
  logic       alert_cond;

  // Bus decode: zero-wait access phase, word-aligned index
  always_comb begin
    acc = apb_req.psel && apb_req.penable;
    wr  = acc && apb_req.pwrite;
    rd  = acc && !apb_req.pwrite;
    idx = apb_req.paddr[9:2];
    for (int c = 0; c < NCH; c++) begin
      fmt[c] = mctm_format(reading[c]);
    end
  end

  // Address map validity
  always_comb begin
    mapped = (mctm_int_chan(idx) >= 0) || (mctm_frac_chan(idx) >= 0) ||
             idx == IDX_EVENT_FLAGS || idx == IDX_SETUP_A || idx == IDX_SETUP_B ||
             idx == IDX_RATE_A || idx == IDX_RATE_B || idx == IDX_HIGH_STATUS ||
             idx == IDX_LOW_STATUS || idx == IDX_FAULT_STATUS;
    mapped = mapped && apb_req.paddr[1:0] == 2'h0 && apb_req.paddr[11:10] == 2'h0;
  end

  assign comp_mode = st.setup[SETUP_COMP_BIT];

  // Alert request from the set flags, busy excluded
  assign alert_cond = st.flags[FLAG_PEAK] | st.flags[FLAG_HIGH] | st.flags[FLAG_LOW] |
                      st.flags[FLAG_FAULT] | st.flags[FLAG_CRIT];

  // Next-state logic
  always_comb begin
    int ic;
    int fc;
    logic status_rd;
    ic = mctm_int_chan(idx);
    fc = mctm_frac_chan(idx);
    status_rd = rd && mapped && idx == IDX_EVENT_FLAGS;
    next_st = st;
    next_st.tick = 1'b0;

    // Read data mux and holding-byte capture
    if (rd) begin
      next_st.prdata = 32'h0;
      if (!mapped) begin
        next_st.prdata = 32'h0;
      end else if (ic >= 0) begin
        next_st.prdata = {24'h0, fmt[ic][15:8]};
        next_st.held_fraction[ic] = fmt[ic][7:0];
      end else if (fc >= 0) begin
        next_st.prdata = {24'h0, st.held_fraction[fc]};
      end else if (idx == IDX_EVENT_FLAGS) begin
        next_st.prdata = {24'h0, st.flags};
      end else if (idx == IDX_SETUP_A || idx == IDX_SETUP_B) begin
        next_st.prdata = {24'h0, st.setup};
      end else if (idx == IDX_RATE_A || idx == IDX_RATE_B) begin
        next_st.prdata = {29'h0, st.rate_code};
      end else begin
        next_st.prdata = {24'h0, st.flags};
      end
    end

    // Writes reach only setup and rate; all else ignored
    if (wr && mapped) begin
      if (idx == IDX_SETUP_A || idx == IDX_SETUP_B) begin
        next_st.setup = apb_req.pwdata[7:0] & SETUP_WMASK;
      end else if (idx == IDX_RATE_A || idx == IDX_RATE_B) begin
        next_st.rate_code = apb_req.pwdata[2:0];
      end
    end

    // Busy follows the converter directly
    next_st.flags[FLAG_BUSY] = cond.busy;

    // Peak change: clear on status read, set wins
    if (status_rd) begin
      next_st.flags[FLAG_PEAK] = 1'b0;
    end
    if (cond.peak_change && remote_peak_compare_enable) begin
      next_st.flags[FLAG_PEAK] = 1'b1;
    end

    // High flag: mode-dependent clear, set wins
    if (!comp_mode && rd && mapped && idx == IDX_HIGH_STATUS && !cond.high_hit) begin
      next_st.flags[FLAG_HIGH] = 1'b0;
    end
    if (comp_mode && st.alert && !alert_next()) begin
      next_st.flags[FLAG_HIGH] = 1'b0;
    end
    if (cond.high_hit) begin
      next_st.flags[FLAG_HIGH] = 1'b1;
    end

    // Low flag
    if (rd && mapped && idx == IDX_LOW_STATUS && !cond.low_hit) begin
      next_st.flags[FLAG_LOW] = 1'b0;
    end
    if (cond.low_hit) begin
      next_st.flags[FLAG_LOW] = 1'b1;
    end

    // Diode fault flag
    if (rd && mapped && idx == IDX_FAULT_STATUS && !cond.diode_fault) begin
      next_st.flags[FLAG_FAULT] = 1'b0;
    end
    if (cond.diode_fault) begin
      next_st.flags[FLAG_FAULT] = 1'b1;
    end

    // Critical flag follows the live condition
    next_st.flags[FLAG_CRIT] = cond.crit_hit;

    next_st.flags[5] = 1'b0;
    next_st.flags[0] = 1'b0;

    next_st.alert = alert_next();

    // Conversion pacing, held in standby
    if (standby_state) begin
      next_st.rate_cnt = 32'h0;
    end else if (st.rate_cnt + 32'h1 >= mctm_period(st.rate_code, remote_count)) begin
      next_st.rate_cnt = 32'h0;
      next_st.tick = 1'b1;
    end else begin
      next_st.rate_cnt = st.rate_cnt + 32'h1;
    end
  end

  // Alert level for next cycle: live conditions in comparator mode, unmasked set flags in interrupt mode
  function automatic logic alert_next();
    if (comp_mode) begin
      alert_next = cond.high_hit || cond.crit_hit;
    end else begin
      alert_next = !st.setup[SETUP_MASK_BIT] && alert_cond;
    end
  endfunction : alert_next

  // State register
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st           <= '0;
      st.setup     <= SETUP_RESET;
      st.rate_code <= RATE_RESET[2:0];
    end else begin
      st <= next_st;
    end
  end

  // Outputs
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = acc && !mapped;
  assign apb_rsp.prdata  = next_st.prdata;
  assign alert             = st.alert;
  assign standby_state     = st.setup[SETUP_STANDBY_BIT] | standby_pin;
  assign averaging_disable = st.setup[SETUP_AVG_DIS_BIT];
  assign remote_peak_compare_enable = 1'b1;
  assign convert_tick      = st.tick;

  // Bus access steps: one accepted read or write of a mapped index
  sequence seq_reg_read(logic [7:0] which);
    rd && mapped && idx == which;
  endsequence
  sequence seq_reg_write(logic [7:0] which);
    wr && mapped && idx == which;
  endsequence

  // Checks
  chk_hold_capture: assert property (@(posedge sys_clk) disable iff (!rstn)
    rd && mapped && idx == IDX_R1_INTEGER |=> st.held_fraction[1] == $past(fmt[1][7:0]))
    else $error("holding byte not captured");
  chk_fault_code: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_read(IDX_R3_INTEGER) ##0 reading[3].fault |-> apb_rsp.prdata == 32'h80)
    else $error("fault code wrong");
  chk_low_bits_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    st.held_fraction[2][4:0] == 5'h0) else $error("fraction low bits set");
  chk_busy_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
    cond.busy |=> st.flags[FLAG_BUSY]) else $error("busy not set");
  chk_mask_alert: assert property (@(posedge sys_clk) disable iff (!rstn)
    st.setup[SETUP_MASK_BIT] && !comp_mode |=> !alert) else $error("masked alert");
  chk_ro_write: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr && idx == IDX_EVENT_FLAGS && !cond.high_hit ##0 !comp_mode |=>
    st.held_fraction == $past(st.held_fraction)) else $error("ro write took");
  chk_setup_alias: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_write(IDX_SETUP_B) |=> st.setup == ($past(apb_req.pwdata[7:0]) & SETUP_WMASK))
    else $error("setup alias");
  chk_high_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    cond.high_hit |=> st.flags[FLAG_HIGH] [*1]) else $error("high flag");
  chk_standby: assert property (@(posedge sys_clk) disable iff (!rstn)
    st.setup[SETUP_STANDBY_BIT] |-> standby_state) else $error("standby");

  // Data byte layout and the holding byte refresh, fault-free channel 2
  chk_int_return: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_read(IDX_R2_INTEGER) ##0 !reading[2].fault |->
    apb_rsp.prdata == {24'h0, reading[2].integer_part}) else $error("integer byte wrong");
  chk_hold_refresh: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_read(IDX_R2_INTEGER) ##0 !reading[2].fault |=>
    st.held_fraction[2] == {$past(reading[2].fraction), 5'h00}) else $error("hold not refreshed");

  // Flag set paths: a live condition always wins over a clearing read
  chk_peak_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    cond.peak_change && remote_peak_compare_enable |=> st.flags[FLAG_PEAK])
    else $error("peak flag not set");
  chk_low_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    cond.low_hit |=> st.flags[FLAG_LOW]) else $error("low flag not set");
  chk_fault_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    cond.diode_fault |=> st.flags[FLAG_FAULT]) else $error("fault flag not set");
  chk_crit_set: assert property (@(posedge sys_clk) disable iff (!rstn)
    cond.crit_hit |=> st.flags[FLAG_CRIT]) else $error("critical flag not set");

  // Flag clear paths: a read of the matching register once the cause is gone
  chk_peak_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_read(IDX_EVENT_FLAGS) ##0 !cond.peak_change |=> !st.flags[FLAG_PEAK])
    else $error("peak flag not cleared");
  chk_high_rdclear: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_read(IDX_HIGH_STATUS) ##0 (!comp_mode && !cond.high_hit) |=>
    !st.flags[FLAG_HIGH]) else $error("high flag not cleared");
  chk_low_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_read(IDX_LOW_STATUS) ##0 !cond.low_hit |=> !st.flags[FLAG_LOW])
    else $error("low flag not cleared");
  chk_fault_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_read(IDX_FAULT_STATUS) ##0 !cond.diode_fault |=> !st.flags[FLAG_FAULT])
    else $error("fault flag not cleared");

  // Comparator mode: the high flag follows the alert pin, not register reads
  chk_high_compclr: assert property (@(posedge sys_clk) disable iff (!rstn)
    comp_mode && alert && !cond.high_hit && !cond.crit_hit |=> !st.flags[FLAG_HIGH])
    else $error("high flag kept after alert fell");
  chk_high_compkeep: assert property (@(posedge sys_clk) disable iff (!rstn)
    comp_mode && st.flags[FLAG_HIGH] && (cond.high_hit || cond.crit_hit) |=>
    st.flags[FLAG_HIGH]) else $error("high flag lost in comparator mode");
  chk_comp_alert: assert property (@(posedge sys_clk) disable iff (!rstn)
    comp_mode |=> alert == $past(cond.high_hit || cond.crit_hit))
    else $error("comparator alert wrong");

  // Busy alone never raises the alert pin in interrupt mode
  chk_busy_quiet: assert property (@(posedge sys_clk) disable iff (!rstn)
    !st.flags[FLAG_PEAK] && !st.flags[FLAG_HIGH] && !st.flags[FLAG_LOW] &&
    !st.flags[FLAG_FAULT] && !st.flags[FLAG_CRIT] && !comp_mode |=> !alert)
    else $error("alert without a flag");

  // Pacing: one-cycle ticks, counter held at zero in standby, rate alias writes
  chk_tick_pulse: assert property (@(posedge sys_clk) disable iff (!rstn)
    convert_tick |=> !convert_tick) else $error("tick longer than one cycle");
  chk_standby_pace: assert property (@(posedge sys_clk) disable iff (!rstn)
    standby_state |=> st.rate_cnt == 32'h0 && !convert_tick)
    else $error("pacing ran in standby");
  chk_rate_alias: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_write(IDX_RATE_B) |=> st.rate_code == $past(apb_req.pwdata[2:0]))
    else $error("rate alias write lost");

  // A write to a data register leaves every writable register alone
  chk_ro_frac: assert property (@(posedge sys_clk) disable iff (!rstn)
    seq_reg_write(IDX_R1_FRACTION) |=>
    st.setup == $past(st.setup) && st.rate_code == $past(st.rate_code))
    else $error("data register write took effect");

endmodule : mctm_regs
